// >>> actm_params.svh
`ifndef ACTM_PARAMS_SVH
`define ACTM_PARAMS_SVH

// Register byte offsets
`define ACTM_OFF_CTRL 32'h0000_0000
`define ACTM_OFF_TIMING 32'h0000_0004
`define ACTM_OFF_START 32'h0000_0008
`define ACTM_OFF_STATUS 32'h0000_000c
`define ACTM_OFF_RESULT 32'h0000_0010
`define ACTM_OFF_TEMP 32'h0000_0014

// Word indexes of the registers
`define ACTM_IDX_CTRL 3'h0
`define ACTM_IDX_TIMING 3'h1
`define ACTM_IDX_START 3'h2
`define ACTM_IDX_STATUS 3'h3
`define ACTM_IDX_RESULT 3'h4
`define ACTM_IDX_TEMP 3'h5
`define ACTM_IDX_NONE 3'h7

// Control register fields
`define ACTM_CTRL_MODE_LSB 0
`define ACTM_CTRL_NOPD_BIT 2
`define ACTM_CTRL_NOCAL_BIT 3
`define ACTM_CTRL_CHAN_LSB 4
`define ACTM_CTRL_TSTB_BIT 9
`define ACTM_CTRL_ITSTB_BIT 10
`define ACTM_CTRL_RNG_BIT 11

// Timing register fields
`define ACTM_TIM_TVC_LSB 0
`define ACTM_TIM_STC_LSB 8

// Reset values
`define ACTM_RST_MODE 2'h0
`define ACTM_RST_TVC 8'h00
`define ACTM_RST_STC 8'h00

// Mode codes
`define ACTM_MODE_10 2'h0
`define ACTM_MODE_12 2'h1
`define ACTM_MODE_8 2'h2

// Channel map
`define ACTM_CH_SUPPLY 5'h00
`define ACTM_CH_INT_TEMP 5'h1f

// Timing counts in converter clock ticks, and the temperature offset in kelvin
`define ACTM_SAMPLE_BASE 9'h002
`define ACTM_CAL_TICKS 9'h002
`define ACTM_TEMP_OFFSET_K 11'h005

`endif

// >>> actm_pkg.sv
package actm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SYNC,
        ST_SAMPLE,
        ST_DIST,
        ST_CAL,
        ST_WRITE
    } actm_phase_t;

    typedef enum logic [1:0] {
        KIND_SUPPLY,
        KIND_VOLT,
        KIND_CURR,
        KIND_TEMP
    } actm_kind_t;

    typedef struct packed {
        actm_phase_t phase;
        logic [9:0] div_cnt;
        logic [8:0] ph_cnt;
        logic [1:0] mode;
        logic no_pd;
        logic no_cal;
        logic [4:0] chan;
        logic tstb;
        logic itstb;
        logic rng4v;
        logic [7:0] tvc;
        logic [7:0] stc;
        logic busy;
        logic sample;
        logic valid;
        logic miss;
        logic powered;
        logic [11:0] held;
        logic [11:0] result;
        logic excite_large;
        logic excite_large_int;
        logic wr_pend;
        logic [2:0] wr_idx;
        logic [31:0] rdata;
        logic readyout;
    } actm_state_t;

endpackage

// >>> actm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "actm_params.svh"

// Notes on behaviour
// - Diode current is ten times larger while the strobe is low.
// - In 10-bit mode one temperature count equals one kelvin.
// - In 8-bit mode one temperature count equals four kelvin.
// - In 12-bit mode temperature still resolves only one kelvin.
// - 10-bit temperature result is plain binary kelvin, 273 reads 0x111.
// - Temperature readings sit five kelvin above the true value.
// - Every result is aligned to the top bit of the result bus.
// - A 5-bit binary channel select picks one of 32 inputs.
// - Channel 0 is core supply, channel 31 the internal diode.
// - Quad q maps voltage, current, temperature pads to 3q+1..3q+3.
// - A temperature pad used for voltage offers only the 4 V range.
// - Mode 00 is 10-bit, 01 is 12-bit, 10 is 8-bit.
// - Sampling flag spans the sample phase, busy spans the whole conversion.
module actm_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [11:0] analog_code,
    input wire logic [9:0] diode_kelvin,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [4:0] channel_select,
    output logic temp_strobe,
    output logic internal_temp_strobe,
    output logic excite_large,
    output logic excite_large_int,
    output logic prescale_4v,
    output logic sample,
    output logic busy,
    output logic result_valid,
    output logic [11:0] result
);

    actm_pkg::actm_state_t s_q;
    actm_pkg::actm_state_t s_d;
    logic tick;
    logic start;

    // Result bits of a mode; the unused code behaves as 10-bit
    function automatic logic [3:0] mode_bits(input logic [1:0] m);
        unique case (m)
            `ACTM_MODE_12: mode_bits = 4'hc;
            `ACTM_MODE_8: mode_bits = 4'h8;
            default: mode_bits = 4'ha;
        endcase
    endfunction

    // Keep the top bits of a full-scale code, zero below them
    function automatic logic [11:0] justify(input logic [11:0] c,
                                            input logic [1:0] m);
        unique case (m)
            `ACTM_MODE_12: justify = c;
            `ACTM_MODE_8: justify = {c[11:4], 4'h0};
            default: justify = {c[11:2], 2'h0};
        endcase
    endfunction

    // Pad kind behind a channel number
    function automatic actm_pkg::actm_kind_t chan_kind(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c == `ACTM_CH_SUPPLY) begin
            chan_kind = actm_pkg::KIND_SUPPLY;
        end else if (c == `ACTM_CH_INT_TEMP) begin
            chan_kind = actm_pkg::KIND_TEMP;
        end else begin
            r = (c - 5'h01) % 5'h03;
            unique case (r)
                5'h00: chan_kind = actm_pkg::KIND_VOLT;
                5'h01: chan_kind = actm_pkg::KIND_CURR;
                default: chan_kind = actm_pkg::KIND_TEMP;
            endcase
        end
    endfunction

    // Quad number of a pad channel, zero for the internal ones
    function automatic logic [3:0] chan_quad(input logic [4:0] c);
        logic [4:0] q;
        q = 5'h00;
        if (c != `ACTM_CH_SUPPLY && c != `ACTM_CH_INT_TEMP) begin
            q = (c - 5'h01) / 5'h03;
        end
        chan_quad = q[3:0];
    endfunction

    // Register read view
    function automatic logic [31:0] rd_word(input actm_pkg::actm_state_t v,
                                            input logic [2:0] idx);
        rd_word = 32'h0000_0000;
        unique case (idx)
            `ACTM_IDX_CTRL: begin
                rd_word[`ACTM_CTRL_MODE_LSB +: 2] = v.mode;
                rd_word[`ACTM_CTRL_NOPD_BIT] = v.no_pd;
                rd_word[`ACTM_CTRL_NOCAL_BIT] = v.no_cal;
                rd_word[`ACTM_CTRL_CHAN_LSB +: 5] = v.chan;
                rd_word[`ACTM_CTRL_TSTB_BIT] = v.tstb;
                rd_word[`ACTM_CTRL_ITSTB_BIT] = v.itstb;
                rd_word[`ACTM_CTRL_RNG_BIT] = v.rng4v;
            end
            `ACTM_IDX_TIMING: begin
                rd_word[`ACTM_TIM_TVC_LSB +: 8] = v.tvc;
                rd_word[`ACTM_TIM_STC_LSB +: 8] = v.stc;
            end
            `ACTM_IDX_STATUS: begin
                rd_word = {21'h000000, chan_quad(v.chan),
                           chan_kind(v.chan), v.powered, v.miss,
                           v.valid, v.sample, v.busy};
            end
            `ACTM_IDX_RESULT: rd_word = {20'h00000, v.result};
            `ACTM_IDX_TEMP: rd_word = {22'h000000, v.result[11:2]};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    // Bus slave, register writes and the conversion sequencer
    always_comb begin
        s_d = s_q;
        start = 1'b0;
        s_d.readyout = 1'b1;
        // Converter clock is one tick per 4*(1+divider) cycles
        tick = (s_q.div_cnt == {s_q.tvc, 2'h3});
        s_d.div_cnt = tick ? 10'h000 : s_q.div_cnt + 10'h001;
        // Data phase of a write lands here
        s_d.wr_pend = 1'b0;
        if (s_q.wr_pend) begin
            unique case (s_q.wr_idx)
                `ACTM_IDX_CTRL: begin
                    s_d.mode = hwdata[`ACTM_CTRL_MODE_LSB +: 2];
                    s_d.no_pd = hwdata[`ACTM_CTRL_NOPD_BIT];
                    s_d.no_cal = hwdata[`ACTM_CTRL_NOCAL_BIT];
                    s_d.chan = hwdata[`ACTM_CTRL_CHAN_LSB +: 5];
                    s_d.tstb = hwdata[`ACTM_CTRL_TSTB_BIT];
                    s_d.itstb = hwdata[`ACTM_CTRL_ITSTB_BIT];
                    s_d.rng4v = hwdata[`ACTM_CTRL_RNG_BIT];
                end
                `ACTM_IDX_TIMING: begin
                    s_d.tvc = hwdata[`ACTM_TIM_TVC_LSB +: 8];
                    s_d.stc = hwdata[`ACTM_TIM_STC_LSB +: 8];
                end
                `ACTM_IDX_START: start = hwdata[0] && !s_q.busy;
                default: start = 1'b0;
            endcase
        end
        // Large excitation flows while the strobe is low
        s_d.excite_large = !s_d.tstb;
        s_d.excite_large_int = !s_d.itstb;
        // Conversion phases
        unique case (s_q.phase)
            actm_pkg::ST_IDLE: begin
                if (start) begin
                    s_d.phase = actm_pkg::ST_SYNC;
                    s_d.busy = 1'b1;
                    s_d.valid = 1'b0;
                    s_d.powered = 1'b1;
                end
            end
            actm_pkg::ST_SYNC: begin
                s_d.phase = actm_pkg::ST_SAMPLE;
                s_d.sample = 1'b1;
                s_d.div_cnt = 10'h000;
                s_d.ph_cnt = `ACTM_SAMPLE_BASE + {1'b0, s_q.stc};
            end
            actm_pkg::ST_SAMPLE: begin
                if (tick) begin
                    s_d.ph_cnt = s_q.ph_cnt - 9'h001;
                    if (s_q.ph_cnt == 9'h001) begin
                        s_d.phase = actm_pkg::ST_DIST;
                        s_d.sample = 1'b0;
                        s_d.ph_cnt = {5'h00, mode_bits(s_q.mode)};
                        // Diode must still be strobed at sample end
                        s_d.miss = 1'b0;
                        if (chan_kind(s_q.chan) == actm_pkg::KIND_TEMP) begin
                            s_d.miss = (s_q.chan == `ACTM_CH_INT_TEMP)
                                ? !s_q.itstb : !s_q.tstb;
                        end
                        s_d.held = analog_code;
                        if (chan_kind(s_q.chan) == actm_pkg::KIND_TEMP &&
                            !(s_q.rng4v && s_q.chan != `ACTM_CH_INT_TEMP &&
                              !s_q.tstb)) begin
                            // 2.5 mV per kelvin: four 12-bit counts each
                            s_d.held = {temp_k(diode_kelvin), 2'h0};
                        end
                    end
                end
            end
            actm_pkg::ST_DIST: begin
                if (tick) begin
                    s_d.ph_cnt = s_q.ph_cnt - 9'h001;
                    if (s_q.ph_cnt == 9'h001) begin
                        s_d.phase = s_q.no_cal ? actm_pkg::ST_WRITE
                                               : actm_pkg::ST_CAL;
                        s_d.ph_cnt = `ACTM_CAL_TICKS;
                    end
                end
            end
            actm_pkg::ST_CAL: begin
                if (tick) begin
                    s_d.ph_cnt = s_q.ph_cnt - 9'h001;
                    if (s_q.ph_cnt == 9'h001) begin
                        s_d.phase = actm_pkg::ST_WRITE;
                    end
                end
            end
            actm_pkg::ST_WRITE: begin
                s_d.phase = actm_pkg::ST_IDLE;
                s_d.busy = 1'b0;
                s_d.valid = 1'b1;
                s_d.powered = s_q.no_pd;
                s_d.result = justify(s_q.held, s_q.mode);
            end
            default: s_d.phase = actm_pkg::ST_IDLE;
        endcase
        // Address phase: reads see this cycle's write already applied
        if (hsel && htrans[1] && hready) begin
            s_d.wr_idx = (haddr[31:5] == 27'h0 && haddr[4:2] <= 3'h5)
                ? haddr[4:2] : `ACTM_IDX_NONE;
            s_d.wr_pend = hwrite;
            if (!hwrite) begin
                s_d.rdata = rd_word(s_d, s_d.wr_idx);
            end
        end
    end

    // Kelvin plus systematic offset, saturating at ten bits
    function automatic logic [9:0] temp_k(input logic [9:0] k);
        logic [10:0] t;
        t = {1'b0, k} + `ACTM_TEMP_OFFSET_K;
        temp_k = t[10] ? 10'h3ff : t[9:0];
    endfunction

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.phase <= actm_pkg::ST_IDLE;
            s_q.mode <= `ACTM_RST_MODE;
            s_q.tvc <= `ACTM_RST_TVC;
            s_q.stc <= `ACTM_RST_STC;
            s_q.excite_large <= 1'b1;
            s_q.excite_large_int <= 1'b1;
            s_q.wr_idx <= `ACTM_IDX_NONE;
            s_q.readyout <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops, except hresp tied low
    assign hreadyout = s_q.readyout;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign channel_select = s_q.chan;
    assign temp_strobe = s_q.tstb;
    assign internal_temp_strobe = s_q.itstb;
    assign excite_large = s_q.excite_large;
    assign excite_large_int = s_q.excite_large_int;
    assign prescale_4v = s_q.rng4v;
    assign sample = s_q.sample;
    assign busy = s_q.busy;
    assign result_valid = s_q.valid;
    assign result = s_q.result;

    // Checks on what the block drives; all of them sleep through reset
    a_excite_ratio: assert property (
        @(posedge hclk) disable iff (!hresetn)
        excite_large == !temp_strobe &&
        excite_large_int == !internal_temp_strobe)
        else $error("excitation not inverse of strobe");

    a_sample_in_busy: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sample |-> busy)
        else $error("sampling outside busy");

    a_valid_after_busy: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(busy) |-> result_valid && $past(s_q.phase) ==
        actm_pkg::ST_WRITE)
        else $error("result not valid when busy falls");

    a_start_busy: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.phase == actm_pkg::ST_IDLE && start |=> busy ##1 sample)
        else $error("start did not begin a conversion");

    // An old result must not look fresh once a new conversion is taken
    a_valid_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.phase == actm_pkg::ST_IDLE && start |=> !result_valid)
        else $error("result still valid after a start");

    a_justify_8bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(result_valid) && s_q.mode == `ACTM_MODE_8
        |-> result[3:0] == 4'h0)
        else $error("8-bit result not top aligned");

    a_justify_10bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(result_valid) && s_q.mode != `ACTM_MODE_12
        |-> result[1:0] == 2'h0)
        else $error("10-bit result not top aligned");

    a_temp_12bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(result_valid) && chan_kind(channel_select) ==
        actm_pkg::KIND_TEMP && !s_q.rng4v |-> result[1:0] == 2'h0)
        else $error("temperature gained sub-kelvin bits");

    a_temp_offset: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.phase == actm_pkg::ST_SAMPLE && s_d.phase == actm_pkg::ST_DIST
        && chan_kind(s_q.chan) == actm_pkg::KIND_TEMP && !s_q.rng4v
        && diode_kelvin == 10'h10c |=> s_q.held == 12'h444)
        else $error("temperature offset wrong");

    // The internal diode is judged by its own strobe, not the quad one
    a_internal_miss: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(sample) && $past(channel_select) == `ACTM_CH_INT_TEMP
        |-> s_q.miss == !$past(internal_temp_strobe))
        else $error("internal diode miss flag wrong");

    a_bus_okay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave stalled or erred");

endmodule
`default_nettype wire

// >>> actm_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Analog sources behind the input multiplexer, as seen by the converter
module actm_analog_model #(
    parameter logic [9:0] QUAD_K = 10'h10c, // Reads 273 K with the offset
    parameter logic [9:0] INT_K = 10'h12c
) (
    input wire logic [4:0] channel_select,
    input wire logic temp_strobe,
    input wire logic internal_temp_strobe,
    output logic [11:0] analog_code,
    output logic [9:0] diode_kelvin
);
    // Unstrobed diodes give a useless reading, never a helpful one
    always_comb begin
        analog_code = {channel_select, 7'h2b};
        if (channel_select == 5'h1f) begin
            diode_kelvin = internal_temp_strobe ? INT_K : ~INT_K;
        end else begin
            diode_kelvin = temp_strobe ? QUAD_K : ~QUAD_K;
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "actm_params.svh"
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic temp_strobe, internal_temp_strobe, excite_large;
    logic excite_large_int, prescale_4v, sample, busy, result_valid;
    logic [4:0] channel_select;
    logic [11:0] analog_code, result;
    logic [9:0] diode_kelvin;
    int bad_count = 0;
    int cmp_count = 0;

    actm_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .analog_code(analog_code),
        .diode_kelvin(diode_kelvin), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .channel_select(channel_select),
        .temp_strobe(temp_strobe),
        .internal_temp_strobe(internal_temp_strobe),
        .excite_large(excite_large), .excite_large_int(excite_large_int),
        .prescale_4v(prescale_4v), .sample(sample), .busy(busy),
        .result_valid(result_valid), .result(result));

    actm_analog_model model_u (.channel_select(channel_select),
        .temp_strobe(temp_strobe),
        .internal_temp_strobe(internal_temp_strobe),
        .analog_code(analog_code), .diode_kelvin(diode_kelvin));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One single AHB-Lite transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        // Only the watchdog may end a wait for the slave
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // The written value reaches the outputs one edge after the data phase
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        @(posedge hclk);
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(name, exp, x);
    endtask

    // Starts one conversion and waits for it under a bounded count
    task automatic convert(input logic [31:0] ctrl, output logic [11:0] res);
        int n;
        wr(`ACTM_OFF_CTRL, ctrl);
        wr(`ACTM_OFF_START, 32'h1);
        for (n = 0; n < 20 && sample !== 1'b1; n++) @(posedge hclk);
        check("busy in sample", 32'h1, {31'h0, busy});
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge hclk);
        check("valid", 32'h1, {31'h0, result_valid});
        check("strobe held", {31'h0, ctrl[9]}, {31'h0, temp_strobe});
        check("chan held", {27'h0, ctrl[8:4]}, {27'h0, channel_select});
        res = result;
    endtask

    task automatic test_reset;
        check("busy", 32'h0, {31'h0, busy});
        check("excite", 32'h1, {31'h0, excite_large});
        check("chan", 32'h0, {27'h0, channel_select});
        check("resp", 32'h0, {31'h0, hresp});
        check("result", 32'h0, {20'h0, result});
        rd_chk("timing", `ACTM_OFF_TIMING, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_channels;
        for (int c = 0; c < 32; c++) begin
            wr(`ACTM_OFF_CTRL, 32'(c) << 4);
            check("chan sel", 32'(c), {27'h0, channel_select});
        end
        wr(`ACTM_OFF_CTRL, 32'h0e00);
        check("strobe", 32'h1, {31'h0, temp_strobe});
        check("excite low", 32'h0, {31'h0, excite_large});
        check("istrobe", 32'h1, {31'h0, internal_temp_strobe});
        check("iexcite", 32'h0, {31'h0, excite_large_int});
        check("range", 32'h1, {31'h0, prescale_4v});
        $display("test channels done");
    endtask

    task automatic test_temp_modes;
        logic [11:0] r;
        logic [11:0] exp [3] = '{12'h444, 12'h444, 12'h440};
        logic [31:0] x;
        for (int m = 0; m < 3; m++) begin
            convert(32'h0230 | 32'(m), r); // channel 3 strobed
            check("temp result", {20'h0, exp[m]}, {20'h0, r});
            rd_chk("temp reg", `ACTM_OFF_TEMP, {22'h0, exp[m][11:2]});
        end
        convert(32'h03e0, r); // channel 30 is the last quad pad
        check("quad9 temp", 32'h444, {20'h0, r});
        // Taking the offset back off must give the diode's true kelvin
        bus(1'b0, `ACTM_OFF_TEMP, 32'h0, x);
        check("calibrated", 32'h10c,
              x - {21'h0, `ACTM_TEMP_OFFSET_K});
        convert(32'h05f0, r);
        check("internal temp", 32'h4c4, {20'h0, r});
        $display("test temp modes done");
    endtask

    task automatic test_voltage;
        logic [11:0] r;
        convert(32'h0011, r);
        check("volt 12b", 32'h0ab, {20'h0, r});
        convert(32'h0010, r);
        check("volt 10b", 32'h0a8, {20'h0, r});
        convert(32'h0002, r);
        check("supply 8b", 32'h020, {20'h0, r});
        rd_chk("result reg", `ACTM_OFF_RESULT, 32'h020);
        $display("test voltage done");
    endtask

    // A second start while busy must not restart the conversion
    task automatic test_busy_start;
        int n;
        wr(`ACTM_OFF_CTRL, 32'h0011);
        wr(`ACTM_OFF_START, 32'h1);
        wr(`ACTM_OFF_START, 32'h1);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge hclk);
        repeat (10) @(posedge hclk);
        check("no restart", 32'h0, {31'h0, busy});
        check("valid kept", 32'h1, {31'h0, result_valid});
        wr(32'h0000_001c, 32'hffff_ffff);
        rd_chk("unmapped", 32'h0000_0018, 32'h0);
        rd_chk("ctrl kept", `ACTM_OFF_CTRL, 32'h0011);
        $display("test busy start done");
    endtask

    // Longer sample window, then the status word for a kept and a lost strobe
    task automatic test_sample_time;
        logic [11:0] r;
        int n;
        wr(`ACTM_OFF_TIMING, 32'h0301);
        wr(`ACTM_OFF_CTRL, 32'h0230);
        wr(`ACTM_OFF_START, 32'h1);
        while (sample !== 1'b1) @(posedge hclk);
        for (n = 0; n < 1000 && sample === 1'b1; n++) @(posedge hclk);
        // Five converter ticks of eight cycles each
        check("sample span", 32'h28, 32'(n));
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge hclk);
        check("long sample temp", 32'h444, {20'h0, result});
        rd_chk("status kept", `ACTM_OFF_STATUS, 32'h0064);
        convert(32'h01e0, r); // Quad 9 diode left unstrobed
        rd_chk("status miss", `ACTM_OFF_STATUS, 32'h04ec);
        $display("test sample time done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_channels();
        test_temp_modes();
        test_voltage();
        test_busy_start();
        test_sample_time();
        print_verdict();
    end
endmodule
`default_nettype wire
